// >>> otp_mode_config_defines.vh
// Constants for the OTP controller register front end
`ifndef OTP_MODE_CONFIG_DEFINES_VH
`define OTP_MODE_CONFIG_DEFINES_VH

// Register byte addresses
`define ADDR_CONTROLLER_MODE       32'h07f40000
`define ADDR_CONTROLLER_STATUS     32'h07f40004
`define ADDR_PROGRAM_WORD_ADDRESS  32'h07f40008
`define ADDR_PROGRAM_WORD_VALUE    32'h07f4000c
`define ADDR_CELL_TIMING_ONE       32'h07f40010
`define ADDR_CELL_TIMING_TWO       32'h07f40014
`define ADDR_COPY_DEST_START       32'h07f40018
`define ADDR_COPY_CELL_START       32'h07f4001c
`define ADDR_COPY_WORD_COUNT       32'h07f40020

// Mode and status register fields
`define MODE_FIELD_HI        2
`define MODE_FIELD_LO        0
`define TEST_ROW_BIT         4
`define HIGH_TEMP_BIT        5
`define ARRAY_SEL_HI         8
`define ARRAY_SEL_LO         6
`define STATUS_READY_BIT     2

// Operating modes
`define MODE_DEEP_STANDBY    3'h0
`define MODE_POWERED_IDLE    3'h1
`define MODE_NORMAL_READ     3'h2
`define MODE_PROGRAM         3'h3
`define MODE_PROGRAM_VERIFY  3'h4
`define MODE_INITIAL_MARGIN  3'h5
`define MODE_AUTO_COPY       3'h6
`define MODE_RESERVED        3'h7

// Array select values
`define ARRAY_SEL_BOTH       3'h0
`define ARRAY_SEL_LAST_VALID 3'h4

// Reset values
`define RESET_MODE           3'h0
`define RESET_ARRAY_SEL      3'h0
`define RESET_WORD           32'h00000000
`define RESET_READY          1'b1

// Mode transition settle time
`define PCLK_MHZ             100
`define MODE_SETTLE_NS       1000
`define MODE_SETTLE_CYCLES   ((`MODE_SETTLE_NS * `PCLK_MHZ + 999) / 1000)

`endif

// >>> mode_transition_timer.v
// Settle timer that holds the mode ready flag low during a mode change
`timescale 1ns/1ns
`default_nettype none
`include "otp_mode_config_defines.vh"

module mode_transition_timer #(
  parameter integer SETTLE_CYCLES = `MODE_SETTLE_CYCLES,
  parameter integer COUNT_WIDTH   = 16
) (
  // Clock and reset
  input  wire                   pclk,
  input  wire                   presetn,
  // Control
  input  wire                   start,
  output reg                    done_reg
);

  localparam [1:0] ST_IDLE   = 2'b01;
  localparam [1:0] ST_SETTLE = 2'b10;
  localparam [31:0]            LAST_WORD  = SETTLE_CYCLES - 1;
  localparam [COUNT_WIDTH-1:0] LAST_COUNT = LAST_WORD[COUNT_WIDTH-1:0];

  reg [1:0]             state_reg;
  reg [COUNT_WIDTH-1:0] count_reg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_IDLE;
      count_reg <= {COUNT_WIDTH{1'b0}};
      done_reg  <= `RESET_READY;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (start)
          begin
            state_reg <= ST_SETTLE;
            count_reg <= {COUNT_WIDTH{1'b0}};
            done_reg  <= 1'b0;
          end
        end
        ST_SETTLE:
        begin
          if (count_reg == LAST_COUNT)
          begin
            state_reg <= ST_IDLE;
            done_reg  <= 1'b1;
          end
          else
          begin
            count_reg <= count_reg + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
          done_reg  <= 1'b1;
        end
      endcase
    end
  end

endmodule // mode_transition_timer
`default_nettype wire

// >>> otp_controller_mode_config.v
// APB register front end and mode configuration of the OTP controller
`timescale 1ns/1ns
`default_nettype none
`include "otp_mode_config_defines.vh"

module otp_controller_mode_config #(
  parameter integer SETTLE_CYCLES = `MODE_SETTLE_CYCLES
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Cell mode control
  output reg  [2:0]  cell_mode,
  output wire        mode_transition_done,
  output reg  [2:0]  cell_array_select,
  output reg         cell_high_temp,
  output reg         cell_test_row,
  // Program request
  output reg  [31:0] cell_word_address,
  output reg  [31:0] cell_word_data,
  output reg         cell_program_request,
  // Cell timing
  output reg  [31:0] cell_timing_one,
  output reg  [31:0] cell_timing_two,
  // Copy engine setup
  output reg  [31:0] copy_dest_start,
  output reg  [31:0] copy_cell_start,
  output reg  [31:0] copy_word_count
);

  // Software-visible configuration
  reg  [2:0]  program_array_select_reg;
  reg  [2:0]  program_array_select_next;
  reg         high_temp_margin_enable_reg;
  reg         high_temp_margin_enable_next;
  reg  [31:0] read_next;
  reg         error_next;
  reg  [31:0] mode_word;
  reg  [31:0] mode_merged;

  wire        setup_phase;
  wire        write_take;
  wire        in_standby;
  wire [2:0]  new_mode;
  wire        mode_write;
  wire        mode_change;
  wire        config_write_ok;
  wire        program_fire;

  // One hit per word of the map; anything else is unmapped
  wire        hit_mode;
  wire        hit_status;
  wire        hit_word_address;
  wire        hit_word_value;
  wire        hit_timing_one;
  wire        hit_timing_two;
  wire        hit_dest_start;
  wire        hit_cell_start;
  wire        hit_word_count;

  function [31:0] merge_bytes;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0]  strobes;
    integer      i;
    begin
      merge_bytes = old_word;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (strobes[i])
        begin
          merge_bytes[i*8 +: 8] = new_word[i*8 +: 8];
        end
      end
    end
  endfunction

  function is_write_to;
    input [31:0] addr;
    input [31:0] target;
    begin
      is_write_to = (addr == target);
    end
  endfunction

  // Exact word match only, so byte offsets inside a word are unmapped
  assign hit_mode         = is_write_to(paddr, `ADDR_CONTROLLER_MODE);
  // Status is read only; a write to it is dropped without error
  assign hit_status       = is_write_to(paddr, `ADDR_CONTROLLER_STATUS);
  assign hit_word_address = is_write_to(paddr, `ADDR_PROGRAM_WORD_ADDRESS);
  assign hit_word_value   = is_write_to(paddr, `ADDR_PROGRAM_WORD_VALUE);
  assign hit_timing_one   = is_write_to(paddr, `ADDR_CELL_TIMING_ONE);
  assign hit_timing_two   = is_write_to(paddr, `ADDR_CELL_TIMING_TWO);
  assign hit_dest_start   = is_write_to(paddr, `ADDR_COPY_DEST_START);
  assign hit_cell_start   = is_write_to(paddr, `ADDR_COPY_CELL_START);
  assign hit_word_count   = is_write_to(paddr, `ADDR_COPY_WORD_COUNT);

  // Zero wait state: pready rises in the first access cycle
  assign setup_phase = psel & ~penable;
  assign write_take  = psel & penable & pready & pwrite;

  always @*
  begin
    mode_word = 32'h00000000;
    mode_word[`MODE_FIELD_HI:`MODE_FIELD_LO] = cell_mode;
    mode_word[`TEST_ROW_BIT]                 = cell_test_row;
    mode_word[`HIGH_TEMP_BIT]                = high_temp_margin_enable_reg;
    mode_word[`ARRAY_SEL_HI:`ARRAY_SEL_LO]   = program_array_select_reg;
    mode_merged = merge_bytes(mode_word, pwdata, pstrb);
  end

  assign mode_write = write_take & hit_mode;
  assign new_mode   = mode_merged[`MODE_FIELD_HI:`MODE_FIELD_LO];

  // mode field read only in transition
  assign mode_change = mode_write & mode_transition_done &
                       (new_mode != cell_mode) & (new_mode != `MODE_RESERVED);

  // only in the two standby modes
  assign in_standby = mode_transition_done &
                      ((cell_mode == `MODE_DEEP_STANDBY) |
                       (cell_mode == `MODE_POWERED_IDLE));

  assign config_write_ok = mode_write & in_standby;

  always @*
  begin
    program_array_select_next    = program_array_select_reg;
    high_temp_margin_enable_next = high_temp_margin_enable_reg;
    if (config_write_ok)
    begin
      if (mode_merged[`ARRAY_SEL_HI:`ARRAY_SEL_LO] <= `ARRAY_SEL_LAST_VALID)
      begin
        program_array_select_next = mode_merged[`ARRAY_SEL_HI:`ARRAY_SEL_LO];
      end
      high_temp_margin_enable_next = mode_merged[`HIGH_TEMP_BIT];
    end
  end

  // Configuration and mode registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      program_array_select_reg    <= `RESET_ARRAY_SEL;
      high_temp_margin_enable_reg <= 1'b0;
      cell_mode                   <= `RESET_MODE;
      cell_array_select           <= `RESET_ARRAY_SEL;
      cell_high_temp              <= 1'b0;
      cell_test_row               <= 1'b0;
    end
    else
    begin
      program_array_select_reg    <= program_array_select_next;
      high_temp_margin_enable_reg <= high_temp_margin_enable_next;
      if (mode_write && mode_transition_done)
      begin
        cell_test_row <= mode_merged[`TEST_ROW_BIT];
      end
      if (mode_change)
      begin
        cell_mode <= new_mode;
        if (new_mode == `MODE_PROGRAM)
        begin
          cell_array_select <= program_array_select_next;
        end
        if ((new_mode == `MODE_PROGRAM_VERIFY) || (new_mode == `MODE_INITIAL_MARGIN))
        begin
          cell_high_temp <= high_temp_margin_enable_next;
        end
        else
        begin
          cell_high_temp <= 1'b0;
        end
      end
    end
  end

  // Program request fires only once the program mode has settled
  assign program_fire = write_take & hit_word_value &
                        (cell_mode == `MODE_PROGRAM) & mode_transition_done;

  // Data and address registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cell_word_address    <= `RESET_WORD;
      cell_word_data       <= `RESET_WORD;
      cell_program_request <= 1'b0;
      cell_timing_one      <= `RESET_WORD;
      cell_timing_two      <= `RESET_WORD;
      copy_dest_start      <= `RESET_WORD;
      copy_cell_start      <= `RESET_WORD;
      copy_word_count      <= `RESET_WORD;
    end
    else
    begin
      cell_program_request <= program_fire;
      if (write_take)
      begin
        if (is_write_to(paddr, `ADDR_PROGRAM_WORD_ADDRESS))
        begin
          cell_word_address <= merge_bytes(cell_word_address, pwdata, pstrb);
        end
        else if (is_write_to(paddr, `ADDR_PROGRAM_WORD_VALUE))
        begin
          cell_word_data <= merge_bytes(cell_word_data, pwdata, pstrb);
        end
        else if (is_write_to(paddr, `ADDR_CELL_TIMING_ONE))
        begin
          cell_timing_one <= merge_bytes(cell_timing_one, pwdata, pstrb);
        end
        else if (is_write_to(paddr, `ADDR_CELL_TIMING_TWO))
        begin
          cell_timing_two <= merge_bytes(cell_timing_two, pwdata, pstrb);
        end
        else if (is_write_to(paddr, `ADDR_COPY_DEST_START))
        begin
          copy_dest_start <= merge_bytes(copy_dest_start, pwdata, pstrb);
        end
        else if (is_write_to(paddr, `ADDR_COPY_CELL_START))
        begin
          copy_cell_start <= merge_bytes(copy_cell_start, pwdata, pstrb);
        end
        else if (is_write_to(paddr, `ADDR_COPY_WORD_COUNT))
        begin
          copy_word_count <= merge_bytes(copy_word_count, pwdata, pstrb);
        end
      end
    end
  end

  // Read decode, sampled during the setup cycle
  always @*
  begin
    read_next  = 32'h00000000;
    error_next = 1'b0;
    if (hit_mode)
    begin
      read_next = mode_word;
    end
    else if (hit_status)
    begin
      read_next[`STATUS_READY_BIT] = mode_transition_done;
    end
    else if (hit_word_address)
    begin
      read_next = cell_word_address;
    end
    else if (hit_word_value)
    begin
      read_next = cell_word_data;
    end
    else if (hit_timing_one)
    begin
      read_next = cell_timing_one;
    end
    else if (hit_timing_two)
    begin
      read_next = cell_timing_two;
    end
    else if (hit_dest_start)
    begin
      read_next = copy_dest_start;
    end
    else if (hit_cell_start)
    begin
      read_next = copy_cell_start;
    end
    else if (hit_word_count)
    begin
      read_next = copy_word_count;
    end
    // Unmapped word answers with an error and zero data
    else
    begin
      error_next = 1'b1;
    end
  end

  // APB answer registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata  <= pwrite ? 32'h00000000 : read_next;
      pready  <= 1'b1;
      pslverr <= error_next;
    end
    // Answer stands one cycle, then drops to zero
    else
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Ready flag drops for the settle time after each accepted mode change
  mode_transition_timer #(
    .SETTLE_CYCLES (SETTLE_CYCLES),
    .COUNT_WIDTH   (16)
  ) settle_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (mode_change),
    .done_reg (mode_transition_done)
  );

endmodule // otp_controller_mode_config
`default_nettype wire

// >>> otp_mode_config_asserts.sv
// Concurrent checks on the OTP controller register front end
`timescale 1ns/1ns
`default_nettype none
`include "otp_mode_config_defines.vh"
module otp_mode_config_asserts (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // Cell side
  input wire logic [2:0]  cell_mode,
  input wire logic        mode_transition_done,
  input wire logic [2:0]  cell_array_select,
  input wire logic        cell_high_temp,
  input wire logic        cell_program_request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  wire hit = paddr[31:8] == 24'h07f400 && paddr[7:0] <= 8'h20 && paddr[1:0] == 2'h0;
  wire pw_wr = psel && penable && pready && pwrite && paddr == `ADDR_PROGRAM_WORD_VALUE;
  chk_zero_wait: assert property (setup |=> pready && !pslverr == hit)
    else $error("ready or error wrong after setup");
  chk_sel_legal: assert property (cell_array_select <= `ARRAY_SEL_LAST_VALID)
    else $error("array select out of range");
  chk_sel_entry: assert property ($changed(cell_array_select) |->
    cell_mode == `MODE_PROGRAM && $past(cell_mode) != `MODE_PROGRAM)
    else $error("array select changed outside program entry");
  chk_temp_scope: assert property (cell_mode != 3'h4 && cell_mode != 3'h5 |->
    !cell_high_temp) else $error("margin temp outside margin reads");
  chk_temp_entry: assert property ($changed(cell_high_temp) |-> $changed(cell_mode))
    else $error("margin temp changed without mode entry");
  chk_ready_drop: assert property ($changed(cell_mode) |-> !mode_transition_done)
    else $error("mode change kept ready high");
  chk_mode_frozen: assert property (!mode_transition_done |=> $stable(cell_mode))
    else $error("mode changed during settle");
  chk_mode_legal: assert property (cell_mode != `MODE_RESERVED)
    else $error("reserved mode entered");
  chk_program_mode_pulse: assert property (cell_program_request |->
    $past(pw_wr) && cell_mode == `MODE_PROGRAM) else $error("stray program request");
endmodule // otp_mode_config_asserts

bind otp_controller_mode_config otp_mode_config_asserts i_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .cell_mode(cell_mode),
  .mode_transition_done(mode_transition_done), .cell_array_select(cell_array_select),
  .cell_high_temp(cell_high_temp), .cell_program_request(cell_program_request));
`default_nettype wire

// >>> otp_cell_model.sv
// Behavioural OTP cell array that records program requests
`timescale 1ns/1ns
`default_nettype none
module otp_cell_model (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Cell control
  input wire logic [2:0]  cell_mode,
  input wire logic [2:0]  cell_array_select,
  input wire logic        cell_program_request,
  input wire logic [31:0] cell_word_address,
  input wire logic [31:0] cell_word_data,
  // Observed programming
  output var logic [31:0] program_mode_count,
  output var logic [31:0] program_mode_addr,
  output var logic [31:0] program_mode_data,
  output var logic [2:0]  program_mode_sel
);
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      program_mode_count <= 32'h0;
      program_mode_addr  <= 32'h0;
      program_mode_data  <= 32'h0;
      program_mode_sel   <= 3'h0;
    end
    else if (cell_program_request && cell_mode == 3'h3)
    begin
      program_mode_count <= program_mode_count + 32'h1;
      program_mode_addr  <= cell_word_address;
      program_mode_data  <= cell_word_data;
      program_mode_sel   <= cell_array_select;
    end
endmodule // otp_cell_model
`default_nettype wire

// >>> otp_controller_mode_config_tb.sv
// Self-checking bench for the OTP controller register front end
`timescale 1ns/1ns
`default_nettype none
`include "otp_mode_config_defines.vh"
module otp_controller_mode_config_tb;
  localparam integer SETTLE = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        mode_transition_done, cell_high_temp, cell_test_row, cell_program_request;
  logic [3:0]  pstrb;
  logic [2:0]  cell_mode, cell_array_select, pm_sel;
  logic [31:0] paddr, pwdata, prdata, rd, pw, pm_count, pm_addr, pm_data;
  logic [31:0] cell_word_address, cell_word_data, cell_timing_one, cell_timing_two;
  logic [31:0] copy_dest_start, copy_cell_start, copy_word_count;
  logic [31:0] expv [2:8];
  int          bad_count, samples_checked, i, s;

  otp_controller_mode_config #(.SETTLE_CYCLES(SETTLE)) i_otp_controller_mode_config (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cell_mode(cell_mode), .mode_transition_done(mode_transition_done),
    .cell_array_select(cell_array_select), .cell_high_temp(cell_high_temp),
    .cell_test_row(cell_test_row), .cell_word_address(cell_word_address),
    .cell_word_data(cell_word_data), .cell_program_request(cell_program_request),
    .cell_timing_one(cell_timing_one), .cell_timing_two(cell_timing_two),
    .copy_dest_start(copy_dest_start), .copy_cell_start(copy_cell_start),
    .copy_word_count(copy_word_count));
  otp_cell_model i_otp_cell_model (.pclk(pclk), .presetn(presetn), .cell_mode(cell_mode),
    .cell_array_select(cell_array_select), .cell_program_request(cell_program_request),
    .cell_word_address(cell_word_address), .cell_word_data(cell_word_data),
    .program_mode_count(pm_count), .program_mode_addr(pm_addr), .program_mode_data(pm_data), .program_mode_sel(pm_sel));

  task print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [255:0] got, input logic [255:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  // Byte lanes of a strobed write, one lane per strobe bit
  function automatic logic [31:0] merged(input logic [31:0] old_w,
    input logic [31:0] new_w, input logic [3:0] lanes);
    merged = old_w;
    for (int b = 0; b < 4; b++)
      if (lanes[b])
        merged[b*8 +: 8] = new_w[b*8 +: 8];
  endfunction
  task hang;
    bad_count++;
    $display("mismatch at %0t: wait ran out", $time);
    print_verdict;
  endtask
  // Master holds the request until pready is seen at an edge
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) hang;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // no use of the controller until ready again
  task set_mode(input logic [2:0] sel, input logic ht, input logic tr, input logic [2:0] m);
    int n;
    apb(1'b1, `ADDR_CONTROLLER_MODE, {23'h0, sel, ht, tr, 1'b0, m});
    n = 0;
    do begin @(posedge pclk); n++; end while (mode_transition_done !== 1'b1 && n < 64);
    if (mode_transition_done !== 1'b1) hang;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0; pwdata = 32'h0; pstrb = 4'hf;
    bad_count = 0; samples_checked = 0;
    void'($urandom(82));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset contents, then one place past the map
    for (i = 0; i < 10; i++)
    begin
      apb(1'b0, `ADDR_CONTROLLER_MODE + 4 * i, 32'h0);
      chk({err, rd}, {i == 9, (i == 1) ? 32'h4 : 32'h0}, "reset value");
    end
    for (i = 2; i < 9; i++)
    begin
      expv[i] = $urandom;
      apb(1'b1, `ADDR_CONTROLLER_MODE + 4 * i, expv[i]);
    end
    for (i = 2; i < 9; i++)
    begin
      apb(1'b0, `ADDR_CONTROLLER_MODE + 4 * i, 32'h0);
      chk(rd, expv[i], "readback");
    end
    chk({cell_word_address, cell_word_data, cell_timing_one, cell_timing_two,
      copy_dest_start, copy_cell_start, copy_word_count}, {expv[2], expv[3], expv[4],
      expv[5], expv[6], expv[7], expv[8]}, "register outputs");
    // Only strobed bytes change
    pw = $urandom;
    pstrb <= 4'h5;
    apb(1'b1, `ADDR_COPY_WORD_COUNT, pw);
    pstrb <= 4'hf;
    apb(1'b0, `ADDR_COPY_WORD_COUNT, 32'h0);
    chk(rd, merged(expv[8], pw, 4'h5), "byte strobes");
    // Every legal array select, margin bit both ways
    for (s = 0; s < 5; s++)
    begin
      set_mode(s[2:0], s[0], 1'b0, `MODE_POWERED_IDLE);
      set_mode(s[2:0], s[0], s[1], `MODE_PROGRAM);
      chk(cell_array_select, s[2:0], "array select");
      chk(cell_test_row, s[1], "test row");
      set_mode(3'((s + 1) % 5), ~s[0], s[1], `MODE_PROGRAM);
      apb(1'b0, `ADDR_CONTROLLER_MODE, 32'h0);
      chk(rd[8:5], {s[2:0], s[0]}, "config locked");
      pw = $urandom;
      apb(1'b1, `ADDR_PROGRAM_WORD_VALUE, pw);
      repeat (2) @(posedge pclk);
      chk({pm_count, pm_addr, pm_data, pm_sel}, {s + 1, expv[2], pw, s[2:0]},
        "program request");
      set_mode(s[2:0], s[0], s[1], 3'(`MODE_PROGRAM_VERIFY + s[1]));
      chk(cell_high_temp, s[0], "margin temp");
      set_mode(s[2:0], s[0], s[1], `MODE_NORMAL_READ);
      chk(cell_high_temp, 1'b0, "normal read temp");
      set_mode(s[2:0], s[0], s[1], `MODE_DEEP_STANDBY);
    end
    // Reserved select and mode values are dropped
    set_mode(3'h5, 1'b0, 1'b0, `MODE_POWERED_IDLE);
    apb(1'b1, `ADDR_CONTROLLER_MODE, 32'h1c7);
    apb(1'b0, `ADDR_CONTROLLER_MODE, 32'h0);
    chk({rd[8:6], rd[2:0]}, {3'h4, 3'h1}, "reserved values");
    // Second mode write lands inside the settle time
    apb(1'b1, `ADDR_CONTROLLER_MODE, 32'h102);
    apb(1'b0, `ADDR_CONTROLLER_STATUS, 32'h0);
    chk({err, rd}, {1'b0, 32'h0}, "ready low while settling");
    set_mode(3'h4, 1'b0, 1'b0, `MODE_PROGRAM);
    chk(cell_mode, `MODE_NORMAL_READ, "mode locked while settling");
    print_verdict;
  end
endmodule // otp_controller_mode_config_tb
`default_nettype wire
